// ===== rtl/bte_cfg.svh
`ifndef BTE_CFG_SVH
`define BTE_CFG_SVH

// status flag positions
`define BTE_FLAG_C 3'd0
`define BTE_FLAG_Z 3'd1
`define BTE_FLAG_N 3'd2
`define BTE_FLAG_V 3'd3
`define BTE_FLAG_S 3'd4
`define BTE_FLAG_H 3'd5
`define BTE_FLAG_T 3'd6
`define BTE_FLAG_I 3'd7

// reset values
`define BTE_STATUS_FLAGS_REGISTER_RST 8'h00
`define BTE_BYTE_RST 8'h00

// execution lengths in clock cycles
`define BTE_CYC_ONE    2'd1
`define BTE_CYC_IO_BIT 2'd2
`define BTE_CYC_MEM    2'd2
`define BTE_CYC_SLEEP  2'd3

// pointer register pair; indirect access uses only the low one
`define BTE_ZLO_IDX 5'd30
`define BTE_ZHI_IDX 5'd31

`endif

// ===== rtl/bte_pkg.sv
`default_nettype none
package bte_pkg;

  typedef enum logic [4:0] {
    op_nop,
    op_ld_indirect,
    op_st_indirect,
    op_mov,
    op_ldi,
    op_in,
    op_out,
    op_io_bit_set_op,
    op_io_bit_clear_op,
    op_logical_shift_up,
    op_logical_shift_down,
    op_rotate_up_through_carry,
    op_rotate_down_through_carry,
    op_arithmetic_shift_down,
    op_swap,
    op_generic_flag_set,
    op_generic_flag_clear,
    op_bit_to_transfer_flag,
    op_transfer_flag_to_bit,
    op_overflow_flag_force_one,
    op_overflow_flag_force_zero,
    op_signed_flag_force_one,
    op_signed_flag_force_zero,
    op_half_carry_force_one,
    op_half_carry_force_zero,
    op_sleep,
    op_watchdog_restart_op
  } bte_op_e;

  typedef struct packed {
    bte_op_e    op;      // instruction
    logic [4:0] rd;      // destination / source general register
    logic [4:0] rr;      // second source general register
    logic [5:0] io_addr; // i/o register address
    logic [2:0] bsel;    // bit or flag index
    logic [7:0] imm;     // immediate constant
  } bte_cmd_s;

  typedef enum logic {
    st_idle,
    st_busy
  } bte_state_e;

endpackage

`default_nettype wire

// ===== rtl/bte_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "bte_cfg.svh"
module bte_exec
  import bte_pkg::*;
(
  input  wire logic     i_clk,            // core clock, 25 MHz
  input  wire logic     i_rst,            // async reset, active high
  input  wire logic     i_valid,          // instruction offered
  input  wire bte_cmd_s i_cmd,            // instruction and operands
  input  wire logic     i_wake,           // leave low-power state
  input  wire logic     i_sleep_mode,     // selected low-power state
  output logic          o_ready,          // can take an instruction
  output logic          o_done,           // instruction completed
  output logic [7:0]    o_status_flags_register,           // status flags register
  output logic [7:0]    o_result,         // last general register write
  output logic          o_io_wr,          // i/o register written
  output logic [5:0]    o_io_addr,        // address of that write
  output logic [7:0]    o_io_data,        // value of that write
  output logic          o_sleep,          // low-power state active
  output logic          o_sleep_mode,     // low-power state entered
  output logic          o_wdt_restart     // watchdog restart pulse
);

  bte_state_e state_reg;
  bte_cmd_s   cmd_reg;
  logic [1:0] cnt_reg;
  logic [7:0] status_flags_register_reg;
  logic [7:0] gpr_reg [32];
  logic [7:0] io_reg  [64];
  logic [7:0] mem_reg [64];
  logic       sleep_reg;
  bte_cmd_s   cur;
  logic       accept, fire, rf_we, io_we, mem_we, sleep_set, watchdog_restart_op;
  logic [1:0] len;
  logic [7:0] rdv, rrv, rf_data, io_data, status_flags_register_next;
  logic [5:0] zidx;

  // execution length of each instruction
  function automatic logic [1:0] op_cycles(input bte_op_e op);
    case (op)
      op_io_bit_set_op,
      op_io_bit_clear_op:  return `BTE_CYC_IO_BIT;
      op_ld_indirect,
      op_st_indirect:      return `BTE_CYC_MEM;
      op_sleep:            return `BTE_CYC_SLEEP;
      default:             return `BTE_CYC_ONE;
    endcase
  endfunction
  // z, c, n, v after a shift or rotate; s and h are left alone
  function automatic logic [7:0] shift_flags(input logic [7:0] sr,
                                             input logic [7:0] res,
                                             input logic       cout);
    logic [7:0] s;
    s = sr;
    s[`BTE_FLAG_C] = cout;
    s[`BTE_FLAG_Z] = (res == 8'h00);
    s[`BTE_FLAG_N] = res[7];
    s[`BTE_FLAG_V] = res[7] ^ cout;
    return s;
  endfunction
  // handshake; a sleeping core takes nothing until woken
  assign o_ready = (state_reg == st_idle) && !sleep_reg;
  assign accept  = i_valid && o_ready;
  assign cur     = (state_reg == st_idle) ? i_cmd : cmd_reg;
  assign len     = op_cycles(i_cmd.op);
  // effects land on the last cycle of an instruction
  assign fire    = (accept && len == `BTE_CYC_ONE) ||
                   (state_reg == st_busy && cnt_reg == 2'd1);
  assign rdv     = gpr_reg[cur.rd];
  assign rrv     = gpr_reg[cur.rr];
  assign zidx    = gpr_reg[`BTE_ZLO_IDX][5:0]; // small data space

  // operation decode and datapath
  always_comb
  begin
    rf_we     = 1'b0;
    rf_data   = rdv;
    io_we     = 1'b0;
    io_data   = io_reg[cur.io_addr];
    mem_we    = 1'b0;
    status_flags_register_next = status_flags_register_reg;
    sleep_set = 1'b0;
    watchdog_restart_op       = 1'b0;
    case (cur.op)
      op_ld_indirect:
      begin
        rf_we   = 1'b1;
        rf_data = mem_reg[zidx];
      end
      op_st_indirect:               mem_we = 1'b1;
      op_mov:
      begin
        rf_we   = 1'b1;
        rf_data = rrv;
      end
      op_ldi:
      begin
        rf_we   = 1'b1;
        rf_data = cur.imm;
      end
      op_in:
      begin
        rf_we   = 1'b1;
        rf_data = io_reg[cur.io_addr];
      end
      op_out:
      begin
        io_we   = 1'b1;
        io_data = rdv;
      end
      op_io_bit_set_op,
      op_io_bit_clear_op:
      begin
        io_we             = 1'b1;
        io_data[cur.bsel] = (cur.op == op_io_bit_set_op);
      end
      op_logical_shift_up:
      begin
        rf_we     = 1'b1;
        rf_data   = {rdv[6:0], 1'b0};
        status_flags_register_next = shift_flags(status_flags_register_reg, rf_data, rdv[7]);
      end
      op_logical_shift_down:
      begin
        rf_we     = 1'b1;
        rf_data   = {1'b0, rdv[7:1]};
        status_flags_register_next = shift_flags(status_flags_register_reg, rf_data, rdv[0]);
      end
      op_rotate_up_through_carry:
      begin
        rf_we     = 1'b1;
        rf_data   = {rdv[6:0], status_flags_register_reg[`BTE_FLAG_C]};
        status_flags_register_next = shift_flags(status_flags_register_reg, rf_data, rdv[7]);
      end
      op_rotate_down_through_carry:
      begin
        rf_we     = 1'b1;
        rf_data   = {status_flags_register_reg[`BTE_FLAG_C], rdv[7:1]};
        status_flags_register_next = shift_flags(status_flags_register_reg, rf_data, rdv[0]);
      end
      op_arithmetic_shift_down:
      begin
        rf_we     = 1'b1;
        rf_data   = {rdv[7], rdv[7:1]};
        status_flags_register_next = shift_flags(status_flags_register_reg, rf_data, rdv[0]);
      end
      op_swap:
      begin
        rf_we   = 1'b1;
        rf_data = {rdv[3:0], rdv[7:4]};
      end
      op_generic_flag_set:          status_flags_register_next[cur.bsel] = 1'b1;
      op_generic_flag_clear:        status_flags_register_next[cur.bsel] = 1'b0;
      op_bit_to_transfer_flag:
        status_flags_register_next[`BTE_FLAG_T] = rdv[cur.bsel];
      op_transfer_flag_to_bit:
      begin
        rf_we             = 1'b1;
        rf_data[cur.bsel] = status_flags_register_reg[`BTE_FLAG_T];
      end
      op_overflow_flag_force_one:   status_flags_register_next[`BTE_FLAG_V] = 1'b1;
      op_overflow_flag_force_zero:  status_flags_register_next[`BTE_FLAG_V] = 1'b0;
      op_signed_flag_force_one:     status_flags_register_next[`BTE_FLAG_S] = 1'b1;
      op_signed_flag_force_zero:    status_flags_register_next[`BTE_FLAG_S] = 1'b0;
      op_half_carry_force_one:      status_flags_register_next[`BTE_FLAG_H] = 1'b1;
      op_half_carry_force_zero:     status_flags_register_next[`BTE_FLAG_H] = 1'b0;
      op_sleep:                     sleep_set = 1'b1;
      op_watchdog_restart_op:       watchdog_restart_op = 1'b1;
      default:                      rf_we = 1'b0;
    endcase
  end

  // sequencing of multi-cycle instructions
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= st_idle;
      cnt_reg   <= 2'd0;
      cmd_reg   <= '0;
    end
    else
    begin
      case (state_reg)
        st_idle:
          if (accept && len != `BTE_CYC_ONE)
          begin
            state_reg <= st_busy;
            cnt_reg   <= len - 2'd1;
            cmd_reg   <= i_cmd;
          end
        st_busy:
        begin
          cnt_reg <= cnt_reg - 2'd1;
          if (cnt_reg == 2'd1)
            state_reg <= st_idle;
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // status flags register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      status_flags_register_reg <= `BTE_STATUS_FLAGS_REGISTER_RST;
    else if (fire)
      status_flags_register_reg <= status_flags_register_next;
  end

  // general registers; no reset, as in a plain register file
  always_ff @(posedge i_clk)
  begin
    if (fire && rf_we)
      gpr_reg[cur.rd] <= rf_data;
  end

  // i/o space is read-modify-write, so a bit op keeps its neighbours
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      for (int k = 0; k < 64; k++)
        io_reg[k] <= `BTE_BYTE_RST;
    else if (fire && io_we)
      io_reg[cur.io_addr] <= io_data;
  end

  // data memory behind the low register of the pointer pair
  always_ff @(posedge i_clk)
  begin
    if (fire && mem_we)
      mem_reg[zidx] <= rdv;
  end

  // observable results, registered
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_done        <= 1'b0;
      o_result      <= `BTE_BYTE_RST;
      o_io_wr       <= 1'b0;
      o_io_addr     <= 6'h00;
      o_io_data     <= `BTE_BYTE_RST;
      o_wdt_restart <= 1'b0;
    end
    else
    begin
      o_done        <= fire;
      o_io_wr       <= fire && io_we;
      o_wdt_restart <= fire && watchdog_restart_op;
      if (fire && rf_we)
        o_result <= rf_data;
      if (fire && io_we)
      begin
        o_io_addr <= cur.io_addr;
        o_io_data <= io_data;
      end
    end
  end

  // low-power state; wake wins only once the sleep has completed
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sleep_reg    <= 1'b0;
      o_sleep_mode <= 1'b0;
    end
    else if (fire && sleep_set)
    begin
      sleep_reg    <= 1'b1;
      o_sleep_mode <= cur.imm[0] | i_sleep_mode;
    end
    else if (i_wake)
      sleep_reg <= 1'b0;
  end

  // flopped state straight out to the pins
  assign o_sleep = sleep_reg;
  assign o_status_flags_register  = status_flags_register_reg;
endmodule
`default_nettype wire

// ===== dv/bte_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bte_exec_checker
  import bte_pkg::*;
(
  input wire logic       i_clk,         // clock
  input wire logic       i_rst,         // reset
  input wire logic       i_valid,       // offer
  input wire bte_cmd_s   i_cmd,         // command
  input wire logic       i_wake,        // wake
  input wire logic       i_sleep_mode,  // mode
  input wire logic       o_ready,       // ready
  input wire logic       o_done,        // done
  input wire logic [7:0] o_status_flags_register,        // flags
  input wire logic [7:0] o_result,      // result
  input wire logic       o_io_wr,       // io write
  input wire logic [5:0] o_io_addr,     // io addr
  input wire logic [7:0] o_io_data,     // io data
  input wire logic       o_sleep,       // asleep
  input wire logic       o_sleep_mode,  // mode seen
  input wire logic       o_wdt_restart  // restart
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // offer taken at this edge
  logic acc;
  assign acc = i_valid && o_ready;

  io_bit_set_a: assert property (
    acc && i_cmd.op == op_io_bit_set_op |=> !o_done ##1 o_done && o_io_wr
    && o_io_data[$past(i_cmd.bsel, 2)] && o_io_addr == $past(i_cmd.io_addr, 2)
  ) else $error("io bit set wrong");
  io_bit_clear_a: assert property (
    acc && i_cmd.op == op_io_bit_clear_op |=> !o_done ##1 o_done && o_io_wr
    && !o_io_data[$past(i_cmd.bsel, 2)] && $stable(o_status_flags_register)
  ) else $error("io bit clear wrong");
  rotate_up_a: assert property (
    acc && i_cmd.op == op_rotate_up_through_carry |=> o_done
    && o_result[0] == $past(o_status_flags_register[0]) && o_status_flags_register[5:4] == $past(o_status_flags_register[5:4])
    && o_status_flags_register[3:1] == {o_status_flags_register[2] ^ o_status_flags_register[0], o_result[7], o_result == 8'h00}
  ) else $error("rotate up wrong");
  flag_to_bit_a: assert property (
    acc && i_cmd.op == op_transfer_flag_to_bit |=> o_done && $stable(o_status_flags_register)
    && o_result[$past(i_cmd.bsel)] == o_status_flags_register[6]
  ) else $error("flag to bit wrong");
  generic_set_a: assert property (
    acc && i_cmd.op == op_generic_flag_set |=> o_done
    && o_status_flags_register == ($past(o_status_flags_register) | (8'h01 << $past(i_cmd.bsel)))
  ) else $error("flag set wrong");
  overflow_zero_a: assert property (
    acc && i_cmd.op == op_overflow_flag_force_zero |=> o_done
    && o_status_flags_register == ($past(o_status_flags_register) & 8'hf7)
  ) else $error("overflow clear wrong");
  sleep_length_a: assert property (
    acc && i_cmd.op == op_sleep |=> !o_done [*2] ##1 o_done && o_sleep
    && $stable(o_status_flags_register)
  ) else $error("sleep wrong");
  wdt_pulse_a: assert property (
    acc && i_cmd.op == op_watchdog_restart_op |=> o_done && o_wdt_restart
    && $stable(o_status_flags_register)
  ) else $error("watchdog restart wrong");
  // main scenarios reached
  cover property (acc && i_cmd.op == op_sleep);
  cover property (o_io_wr && o_done);
  cover property (o_wdt_restart);
endmodule

bind bte_exec bte_exec_checker u_bte_exec_checker (
  .i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_cmd(i_cmd),
  .i_wake(i_wake), .i_sleep_mode(i_sleep_mode), .o_ready(o_ready),
  .o_done(o_done), .o_status_flags_register(o_status_flags_register), .o_result(o_result),
  .o_io_wr(o_io_wr), .o_io_addr(o_io_addr), .o_io_data(o_io_data),
  .o_sleep(o_sleep), .o_sleep_mode(o_sleep_mode),
  .o_wdt_restart(o_wdt_restart)
);
`default_nettype wire

// ===== dv/tb_bit_and_transfer_exec.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_bit_and_transfer_exec;
  import bte_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_valid = 1'b0;
  logic       i_wake = 1'b0;
  logic       i_sleep_mode = 1'b0;
  bte_cmd_s   i_cmd = '0;
  logic       o_ready, o_done, o_io_wr, o_sleep, o_sleep_mode, o_wdt_restart;
  logic [7:0] o_status_flags_register, o_result, o_io_data;
  logic [5:0] o_io_addr;
  logic [7:0] gpr[32], io[64], mem[64], status_flags_register, res;
  int         n_fail, total_checks, seed = 44;

  always #20 i_clk = ~i_clk;

  bte_exec u_bte_exec (
    .i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_cmd(i_cmd),
    .i_wake(i_wake), .i_sleep_mode(i_sleep_mode), .o_ready(o_ready),
    .o_done(o_done), .o_status_flags_register(o_status_flags_register), .o_result(o_result),
    .o_io_wr(o_io_wr), .o_io_addr(o_io_addr), .o_io_data(o_io_data),
    .o_sleep(o_sleep), .o_sleep_mode(o_sleep_mode),
    .o_wdt_restart(o_wdt_restart)
  );

  function automatic bte_cmd_s mk(input int o, r, s, a, b, m);
    mk = '{bte_op_e'(5'(o)), 5'(r), 5'(s), 6'(a), 3'(b), 8'(m)};
  endfunction

  // reference model: old values are read before anything is written
  function automatic void predict(input bte_cmd_s c);
    logic [7:0] a, n;
    logic       cy;
    a = gpr[c.rd];
    n = a;
    cy = status_flags_register[0];
    case (c.op)
      op_ld_indirect: n = mem[gpr[30][5:0]];
      op_st_indirect: mem[gpr[30][5:0]] = a;
      op_mov: n = gpr[c.rr];
      op_ldi: n = c.imm;
      op_in: n = io[c.io_addr];
      op_out: io[c.io_addr] = a;
      op_io_bit_set_op, op_io_bit_clear_op: io[c.io_addr][c.bsel] = c.op[0];
      op_logical_shift_up: {cy, n} = {a, 1'b0};
      op_logical_shift_down: {n, cy} = {1'b0, a};
      op_rotate_up_through_carry: {cy, n} = {a, status_flags_register[0]};
      op_rotate_down_through_carry: {n, cy} = {status_flags_register[0], a};
      op_arithmetic_shift_down: {n, cy} = {a[7], a};
      op_swap: n = {a[3:0], a[7:4]};
      op_generic_flag_set, op_generic_flag_clear: status_flags_register[c.bsel] = c.op[0];
      op_bit_to_transfer_flag: status_flags_register[6] = a[c.bsel];
      op_transfer_flag_to_bit: n[c.bsel] = status_flags_register[6];
      default:
        if (c.op inside {[op_overflow_flag_force_one:op_half_carry_force_zero]})
          status_flags_register[3 + (c.op - 19) / 2] = c.op[0];
    endcase
    // shifts touch V N Z C only, with V taken as N xor C
    if (c.op inside {[op_logical_shift_up:op_arithmetic_shift_down]})
      status_flags_register[3:0] = {n[7] ^ cy, n[7], n == 8'h00, cy};
    if (c.op inside {op_ld_indirect, op_mov, op_ldi, op_in,
                     [op_logical_shift_up:op_swap], op_transfer_flag_to_bit})
    begin
      gpr[c.rd] = n;
      res = n;
    end
  endfunction

  // offer one instruction, then check everything at its done pulse
  task automatic run(input bte_cmd_s c);
    int   k, cyc;
    logic wr;
    wr = c.op inside {op_out, op_io_bit_set_op, op_io_bit_clear_op};
    cyc = c.op inside {op_ld_indirect, op_st_indirect, op_io_bit_set_op,
                       op_io_bit_clear_op} ? 2 : (c.op == op_sleep ? 3 : 1);
    predict(c);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_cmd <= c;
    @(posedge i_clk);
    i_valid <= 1'b0;
    // outputs are read mid-cycle, where they have settled
    for (k = 1; k < 7; k++)
    begin
      @(negedge i_clk);
      if (o_done === 1'b1)
        break;
    end
    `CHK("cycles", cyc, k)
    `CHK("result", res, o_result)
    `CHK("status_flags_register", status_flags_register, o_status_flags_register)
    `CHK("io_wr", wr, o_io_wr)
    if (wr)
    begin
      `CHK("io_data", io[c.io_addr], o_io_data)
      `CHK("io_addr", c.io_addr, o_io_addr)
    end
    `CHK("wdt", c.op == op_watchdog_restart_op, o_wdt_restart)
  endtask

  task close_out;
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // cut a hang short; a clean run needs under a thousand cycles
  initial
  begin
    #160000;
    n_fail++;
    close_out;
  end

  initial
  begin
    bte_cmd_s c;
    int       k;
    status_flags_register = 8'h00;
    res = 8'h00;
    foreach (io[j])
      io[j] = 8'h00;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    `CHK("rst_status_flags_register", 8'h00, o_status_flags_register)
    // registers are not reset, so load them all first
    for (int r = 0; r < 32; r++)
      run(mk(4, r, 0, 0, 0, $random(seed)));
    // pointer at the top of memory, store then load back
    run(mk(4, 30, 0, 0, 0, 8'hff));
    run(mk(2, 0, 7, 0, 0, 0));
    run(mk(1, 9, 0, 0, 0, 0));
    run(mk(31, 0, 0, 0, 0, 0));
    repeat (300)
    begin
      k = 2 + {$random(seed)} % 24;
      if (k == 25)
        k = 26;
      c = mk(k, $random(seed), $random(seed), $random(seed), $random(seed),
             $random(seed));
      if (c.op == op_bit_to_transfer_flag)
        c.rr = c.rd;
      run(c);
    end
    // each way of choosing the low-power state, then wake
    for (int m = 0; m < 3; m++)
    begin
      @(posedge i_clk);
      i_sleep_mode <= m[0];
      run(mk(25, 0, 0, 0, 0, m >> 1));
      `CHK("sleep", 1'b1, o_sleep)
      `CHK("mode", 1'(m[0] | m[1]), o_sleep_mode)
      `CHK("ready", 1'b0, o_ready)
      @(posedge i_clk);
      i_wake <= 1'b1;
      @(posedge i_clk);
      i_wake <= 1'b0;
      @(negedge i_clk);
      `CHK("awake", 1'b0, o_sleep)
      `CHK("ready_back", 1'b1, o_ready)
    end
    close_out;
  end
endmodule
`default_nettype wire
